// ---- hdl/dior_top.v ----
`timescale 1ns/1ps
`include "dior_map.vh"

// Overview of operation
// - pad input feeds two capture registers, each on its own antiphase edge
// - capture registers load only while the input clock enable is high
// - all registers of the cell share one set line and one reset line
// - second clock comes from the antiphase input or an inverted first clock
// - output pair launches on antiphase edges and muxes alternate bits out
// - output launch pair shares one clock enable needed for new values
// - output mux select comes from the clock, never from software
// - tristate variant uses two data and two enable registers with muxes
// - data pair and enable pair each have their own clock enable
// - each phase clocks one data and one enable register, paired together
// - both enables high floats the pad; both low drives the data mux
// - mixed enables float during the high phase, drive the other's data
// - first data loads on first clock edge, second on second, if enabled
// - with clock enable low both edges load no data; only set or reset can still move the output
// - synchronous reset forces output low on either edge, beating set
// - synchronous set without reset forces output high on either edge
// - at power-up the flip-flops are cleared so pad_out and the captures start low, pad_oe high
// - async variant loads data only with preset and clear low, enable high
// - async preset forces high and clear forces low without a clock
module dior_top #(
  parameter ASYNC_PC = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire        first_phase_clock,
  input  wire        antiphase_clock,
  input  wire        pad_in,
  output wire        pad_out,
  output wire        pad_oe,
  output wire        rise_capture_out,
  output wire        fall_capture_out,
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  function [1:0] dior_decode;
    input [11:0] addr;
    reg   [11:0] word;
    begin
      word = {addr[11:2], 2'b00};
      if (word == `DIOR_OFS_CTRL)
        dior_decode = `DIOR_IDX_CTRL;
      else if (word == `DIOR_OFS_DATA)
        dior_decode = `DIOR_IDX_DATA;
      else if (word == `DIOR_OFS_STAT)
        dior_decode = `DIOR_IDX_STAT;
      else
        dior_decode = `DIOR_IDX_NONE;
    end
  endfunction

  function [7:0] dior_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input       strb;
    begin
      dior_merge = strb ? new_val : old_val;
    end
  endfunction

  reg  [`DIOR_CTRL_W-1:0] ctrl_r;
  reg  [`DIOR_DATA_W-1:0] data_r;
  reg                     clk_a_prev_r;
  reg                     clk_b_prev_r;
  reg  [1:0]              capture_r;
  reg                     aw_hold_r;
  reg  [11:0]             aw_addr_r;
  reg                     w_hold_r;
  reg  [31:0]             w_data_r;
  reg  [3:0]              w_strb_r;
  reg                     bvalid_r;
  reg  [1:0]              bresp_r;
  reg                     rvalid_r;
  reg  [1:0]              rresp_r;
  reg  [31:0]             rdata_r;
  reg  [31:0]             rdata_nxt;
  reg  [7:0]              ctrl_byte_nxt;
  reg  [7:0]              data_byte_nxt;

  wire       use_inv;
  wire       shared_set;
  wire       shared_reset_line;
  wire       clk_a_lvl;
  wire       clk_b_lvl;
  wire       rise_a;
  wire       rise_b;
  wire [1:0] edge_hit;
  wire [1:0] cell_q;
  wire [1:0] cell_ce;
  wire [1:0] cell_d0;
  wire [1:0] cell_d1;
  wire       aw_take;
  wire       w_take;
  wire       wr_go;
  wire       ar_take;
  wire [1:0] wr_idx;
  wire [1:0] rd_idx;
  wire [31:0] stat_word;

  assign use_inv           = ctrl_r[`DIOR_CTRL_USE_INV];
  assign shared_set        = ctrl_r[`DIOR_CTRL_SET];
  assign shared_reset_line = ctrl_r[`DIOR_CTRL_RESET];

  // clock phases arrive as sampled levels; edges found against last sample
  assign clk_a_lvl = first_phase_clock;
  assign clk_b_lvl = use_inv ? ~first_phase_clock : antiphase_clock;
  assign rise_a    = clk_a_lvl & ~clk_a_prev_r;
  assign rise_b    = clk_b_lvl & ~clk_b_prev_r;
  assign edge_hit  = {rise_b, rise_a};

  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_a_prev_r <= 1'b0;
      clk_b_prev_r <= 1'b0;
    end else if (clk_en) begin
      clk_a_prev_r <= clk_a_lvl;
      clk_b_prev_r <= clk_b_lvl;
    end
  end

  // input capture pair: bit 0 on the first phase, bit 1 on the second
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_capture
      always @(posedge aclk) begin
        if (!aresetn) begin
          capture_r[gi] <= 1'b0;
        end else if (clk_en && edge_hit[gi]) begin
          if (shared_reset_line)
            capture_r[gi] <= 1'b0;
          else if (shared_set)
            capture_r[gi] <= 1'b1;
          else if (ctrl_r[`DIOR_CTRL_CE_IN])
            capture_r[gi] <= pad_in;
        end
      end
    end
  endgenerate

  assign rise_capture_out = capture_r[0];
  assign fall_capture_out = capture_r[1];

  // cell 0 is the data pair, cell 1 the enable pair; same clocks pair them
  assign cell_ce[0] = ctrl_r[`DIOR_CTRL_CE_DATA];
  assign cell_ce[1] = ctrl_r[`DIOR_CTRL_CE_TRI];
  assign cell_d0[0] = data_r[`DIOR_DATA_DA];
  assign cell_d1[0] = data_r[`DIOR_DATA_DB];
  assign cell_d0[1] = data_r[`DIOR_DATA_EA];
  assign cell_d1[1] = data_r[`DIOR_DATA_EB];

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cell
      dior_ff_cell #(
        .ASYNC_PC (ASYNC_PC)
      ) u_cell (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .clk_en              (clk_en),
        .load_a              (rise_a),
        .load_b              (rise_b),
        .first_edge_data_in  (cell_d0[gi]),
        .second_edge_data_in (cell_d1[gi]),
        .ce                  (cell_ce[gi]),
        .set_in              (shared_set),
        .reset_in            (shared_reset_line),
        .q                   (cell_q[gi])
      );
    end
  endgenerate

  // the enable cell tracks the same phase as the data cell while both clock
  // enables are high, so a high enable floats the pad only during its own phase
  assign pad_out = cell_q[0];
  assign pad_oe  = ~cell_q[1];

  assign stat_word = {27'h0000000,
                      clk_a_lvl,
                      pad_oe,
                      pad_out,
                      capture_r[1],
                      capture_r[0]};

  // register bus: address and data may arrive in either order
  assign s_axi_awready = clk_en & ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = clk_en & ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = clk_en & ~rvalid_r;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign wr_go         = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_idx        = dior_decode(aw_addr_r);
  assign rd_idx        = dior_decode(s_axi_araddr);

  always @* begin
    ctrl_byte_nxt = dior_merge({2'b00, ctrl_r}, w_data_r[7:0], w_strb_r[0]);
    data_byte_nxt = dior_merge({4'h0, data_r}, w_data_r[7:0], w_strb_r[0]);
  end

  always @* begin
    case (rd_idx)
      `DIOR_IDX_CTRL: rdata_nxt = {26'h0000000, ctrl_r};
      `DIOR_IDX_DATA: rdata_nxt = {28'h0000000, data_r};
      `DIOR_IDX_STAT: rdata_nxt = stat_word;
      default:        rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `DIOR_CTRL_RST_VAL;
      data_r    <= `DIOR_DATA_RST_VAL;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `DIOR_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= `DIOR_RESP_OKAY;
        case (wr_idx)
          `DIOR_IDX_CTRL: ctrl_r <= ctrl_byte_nxt[`DIOR_CTRL_W-1:0];
          `DIOR_IDX_DATA: data_r <= data_byte_nxt[`DIOR_DATA_W-1:0];
          // status is read-only; a write there is dropped quietly
          `DIOR_IDX_STAT: bresp_r <= `DIOR_RESP_OKAY;
          default:        bresp_r <= `DIOR_RESP_SLVERR;
        endcase
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `DIOR_RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rdata_nxt;
        rresp_r  <= (rd_idx == `DIOR_IDX_NONE) ? `DIOR_RESP_SLVERR
                                               : `DIOR_RESP_OKAY;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

endmodule // dior_top

// ---- hdl/dior_map.vh ----
`ifndef DIOR_MAP_VH
`define DIOR_MAP_VH

// register bus
`define DIOR_ADDR_W        12
`define DIOR_BUS_W         32
`define DIOR_OFS_CTRL      12'h000
`define DIOR_OFS_DATA      12'h004
`define DIOR_OFS_STAT      12'h008

// decoded register index
`define DIOR_IDX_CTRL      2'h0
`define DIOR_IDX_DATA      2'h1
`define DIOR_IDX_STAT      2'h2
`define DIOR_IDX_NONE      2'h3

// response codes
`define DIOR_RESP_OKAY     2'h0
`define DIOR_RESP_SLVERR   2'h2

// control register fields
`define DIOR_CTRL_USE_INV  0
`define DIOR_CTRL_SET      1
`define DIOR_CTRL_RESET    2
`define DIOR_CTRL_CE_IN    3
`define DIOR_CTRL_CE_DATA  4
`define DIOR_CTRL_CE_TRI   5
`define DIOR_CTRL_W        6
`define DIOR_CTRL_RST_VAL  6'h00

// data register fields
`define DIOR_DATA_DA       0
`define DIOR_DATA_DB       1
`define DIOR_DATA_EA       2
`define DIOR_DATA_EB       3
`define DIOR_DATA_W        4
`define DIOR_DATA_RST_VAL  4'hC

// status register fields
`define DIOR_STAT_RISE     0
`define DIOR_STAT_FALL     1
`define DIOR_STAT_PAD_OUT  2
`define DIOR_STAT_PAD_OE   3
`define DIOR_STAT_CLK_A    4

`endif

// ---- hdl/dior_ff_cell.v ----
`timescale 1ns/1ps

// one double-rate flip-flop: two holding registers and a clock-derived mux
module dior_ff_cell #(
  parameter ASYNC_PC = 0
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire clk_en,
  input  wire load_a,
  input  wire load_b,
  input  wire first_edge_data_in,
  input  wire second_edge_data_in,
  input  wire ce,
  input  wire set_in,
  input  wire reset_in,
  output wire q
);

  reg  hold_a_r;
  reg  hold_b_r;
  reg  sel_b_r;
  wire mux_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_a_r <= 1'b0;
      hold_b_r <= 1'b0;
      sel_b_r  <= 1'b0;
    end else if (clk_en) begin
      if (ASYNC_PC != 0) begin
        // preset and clear act without waiting for an edge
        if (reset_in) begin
          hold_a_r <= 1'b0;
          hold_b_r <= 1'b0;
        end else if (set_in) begin
          hold_a_r <= 1'b1;
          hold_b_r <= 1'b1;
        end else if (ce) begin
          if (load_a) begin
            hold_a_r <= first_edge_data_in;
            sel_b_r  <= 1'b0;
          end
          if (load_b) begin
            hold_b_r <= second_edge_data_in;
            sel_b_r  <= 1'b1;
          end
        end
      end else if (load_a || load_b) begin
        if (reset_in) begin
          hold_a_r <= 1'b0;
          hold_b_r <= 1'b0;
        end else if (set_in) begin
          hold_a_r <= 1'b1;
          hold_b_r <= 1'b1;
        end else if (ce) begin
          if (load_a) begin
            hold_a_r <= first_edge_data_in;
            sel_b_r  <= 1'b0;
          end
          if (load_b) begin
            hold_b_r <= second_edge_data_in;
            sel_b_r  <= 1'b1;
          end
        end
      end
    end
  end

  // select follows the last clock edge that loaded data, never software
  assign mux_q = sel_b_r ? hold_b_r : hold_a_r;

  // async mode overrides the output at once; clear beats preset
  assign q = (ASYNC_PC == 0) ? mux_q :
             reset_in        ? 1'b0  :
             set_in          ? 1'b1  : mux_q;

endmodule // dior_ff_cell

// ---- test/dior_pad_chip.sv ----
`timescale 1ns/1ps

// far-side chip: drives the pad only while the cell floats, never fights it
module dior_pad_chip (
  input  wire pad_out,
  input  wire pad_oe,
  input  wire drv_bit,
  output wire pad
);
  assign pad = pad_oe ? pad_out : drv_bit;
endmodule // dior_pad_chip

// ---- test/dior_props.sv ----
`timescale 1ns/1ps

module dior_props (
  input logic        aclk,
  input logic        aresetn,
  input logic        clk_en,
  input logic        first_phase_clock,
  input logic        antiphase_clock,
  input logic        pad_out,
  input logic        pad_oe,
  input logic        rise_capture_out,
  input logic        fall_capture_out,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // phase edges are levels sampled on aclk, so edges show as sampled changes
  sequence no_b_edge;
    !$rose(antiphase_clock) && !$fell(first_phase_clock);
  endsequence
  sequence no_edge;
    no_b_edge and !$rose(first_phase_clock);
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  chk_reset_clear:
    assert property ($rose(aresetn) |-> !pad_out && pad_oe &&
      !rise_capture_out && !fall_capture_out)
    else $error("outputs not cleared by reset");
  chk_rise_hold:
    assert property (!$rose(first_phase_clock) |=> $stable(rise_capture_out))
    else $error("rise capture moved without first edge");
  chk_fall_hold:
    assert property (no_b_edge |=> $stable(fall_capture_out))
    else $error("fall capture moved without second edge");
  chk_pad_hold:
    assert property (no_edge |=> $stable(pad_out) && $stable(pad_oe))
    else $error("pad changed without a phase edge");
  chk_gate_off:
    assert property (!clk_en |-> !s_axi_awready && !s_axi_wready &&
      !s_axi_arready)
    else $error("ready while clock enable low");
  chk_wr_answer:
    // address and data are held one edge first, so the answer is two late
    assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("no write response two edges after take");
  chk_b_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data one edge after take");
  chk_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_busy_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule // dior_props

bind dior_top dior_props u_props (.aclk, .aresetn, .clk_en,
  .first_phase_clock, .antiphase_clock, .pad_out, .pad_oe,
  .rise_capture_out, .fall_capture_out, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready);

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "dior_map.vh"

module tb;
  logic        aclk, aresetn, clk_en, first_phase_clock, antiphase_clock;
  logic        ext_bit, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, bb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, seed;
  wire         pad_in, pad_out, pad_oe, rise_capture_out, fall_capture_out;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  pins = {pad_oe, pad_out, fall_capture_out, rise_capture_out};
  logic [5:0]  ctrl_v;
  logic [3:0]  data_v;
  logic        dq, tq, er, ef;
  int          error_cnt, tests_run, cyc;

  dior_top uut (.aclk, .aresetn, .clk_en, .first_phase_clock,
    .antiphase_clock, .pad_in, .pad_out, .pad_oe, .rise_capture_out,
    .fall_capture_out, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dior_pad_chip chip (.pad_out, .pad_oe, .drv_bit(ext_bit), .pad(pad_in));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // values are sampled at the negedge: same as the next posedge sees
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic ta, tw, hb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
    cmp({30'h0, r}, {30'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic [1:0] e);
    logic ta, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!hr);
    s_axi_rready <= 1'b0;
    cmp(d, x);
    cmp({30'h0, r}, {30'h0, e});
  endtask

  // reference cell: reset beats set, both ignore the clock enables
  function automatic void upd(input logic b, input logic p);
    logic [2:0] v;
    logic [2:0] en;
    v = {p, b ? data_v[3] : data_v[2], b ? data_v[1] : data_v[0]};
    en = {ctrl_v[3], ctrl_v[5], ctrl_v[4]};
    if (ctrl_v[2] || ctrl_v[1]) begin
      v = {3{!ctrl_v[2]}};
      en = 3'h7;
    end
    if (en[0]) dq = v[0];
    if (en[1]) tq = v[1];
    if (en[2] && b) ef = v[2];
    if (en[2] && !b) er = v[2];
  endfunction

  function automatic logic [31:0] stat_exp();
    return {27'h0, first_phase_clock, ~tq, dq, ef, er};
  endfunction

  task automatic ph(input logic fa, input logic fb, input logic hit,
                    input logic b);
    @(posedge aclk);
    ext_bit <= 1'($urandom);
    first_phase_clock <= fa;
    antiphase_clock <= fb;
    #1;
    if (hit) upd(b, tq ? ext_bit : dq);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    cmp({28'h0, pins}, {28'h0, ~tq, dq, ef, er});
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    {aresetn, first_phase_clock, antiphase_clock, ext_bit} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, bb, dq, tq, er, ef} = 7'h00;
    clk_en = 1'b1;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    ctrl_v = 6'h00;
    data_v = 4'hC;
    seed = $urandom(32'h8467);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DIOR_OFS_CTRL, 32'h00000000, `DIOR_RESP_OKAY);
    rd(`DIOR_OFS_DATA, 32'h0000000C, `DIOR_RESP_OKAY);
    rd(`DIOR_OFS_STAT, stat_exp(), `DIOR_RESP_OKAY);
    rd(12'h00C, 32'h00000000, `DIOR_RESP_SLVERR);
    wr(12'h00C, 32'h0000003F, `DIOR_RESP_SLVERR);
    wr(`DIOR_OFS_STAT, 32'h0000001F, `DIOR_RESP_OKAY);
    rd(`DIOR_OFS_STAT, stat_exp(), `DIOR_RESP_OKAY);
    ph(1'b1, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 48; i++) begin
      ctrl_v = 6'($urandom);
      if (i % 4 != 0) ctrl_v[2:1] = 2'h0;
      data_v = 4'($urandom);
      bb = 1'($urandom);
      wr(`DIOR_OFS_CTRL, {26'h0, ctrl_v}, `DIOR_RESP_OKAY);
      wr(`DIOR_OFS_DATA, {28'h0, data_v}, `DIOR_RESP_OKAY);
      rd(`DIOR_OFS_CTRL, {26'h0, ctrl_v}, `DIOR_RESP_OKAY);
      ph(1'b0, bb, bb | ctrl_v[0], 1'b1);
      ph(1'b1, 1'b0, 1'b1, 1'b0);
      rd(`DIOR_OFS_STAT, stat_exp(), `DIOR_RESP_OKAY);
      // freeze only while the phase clocks stand still
      if (i % 8 == 3) begin
        clk_en <= 1'b0;
        repeat (3) @(posedge aclk);
        clk_en <= 1'b1;
      end
    end
    print_verdict;
  end
endmodule // tb
